// File: logic/cpurst_top.sv
`timescale 1ns/1ps
// Overview of operation
// - After reset, PC loads bytes from FFFF00H, FFFF01H, FFFF02H, low first.
// - Reset sets the system stack pointer to 100H.
// - Reset sets interrupt mask level to 111, blocking maskable requests below level 7.
// - Reset sets wide-mode bit to 1; software never clears it.
// - Reset clears register bank pointer to 000.
// - Reset keeps other core state, defaults I/O registers, drives clock pin high.
// - Address lines start driving on the 11th clock after reset release.
// - Strap low at reset release: 16-bit bus, per-area width selects.
// - Strap high: only low eight data lines, area widths ignored.
// - Writing 1 to clock pin tristate bit floats the divided clock pin.
// - Writing 1 to sysclk tristate bit floats the half-rate clock pin.
// - Both clock pins toggle right after reset release.
// - Tristate bits clear only on reset; software zero writes ignored.
// - Sysclk pin floats at next phase-2 rise, clock pin one pair later.
// - Psram mode bit makes read strobe active on internal reads too.
// - Internal I/O window 0..3FH keeps all strobes high, except psram read.
// - Internal I/O takes zero or one wait by core state, not wait controller.
// - Overlap of external area with I/O window counts as internal access.
// - Non-maskable gets level 7; highest simultaneous request is forwarded.
// - Forwarded request accepted only when level is at least mask level.
// - Traps are taken without mask comparison.
// - Mask-set loads operand into mask; zero acts as one.
// - Mask-all loads 7; mask-set acts immediately after execution.
module cpurst_top #(
  parameter int NSRC = 4
) (
  input  wire logic                MCLK,
  input  wire logic                NRST,
  input  wire logic [7:0]          WB_ADR_I,
  input  wire logic [31:0]         WB_DAT_I,
  output      logic [31:0]         WB_DAT_O,
  input  wire logic                WB_WE_I,
  input  wire logic [3:0]          WB_SEL_I,
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  output      logic                WB_ACK_O,
  input  wire logic                BUS_WIDTH_STRAP,
  output      logic                SYSTEM_CLOCK_OUTPUT,
  output      logic                SYSTEM_CLOCK_OE_N,
  output      logic                CLK_OUT,
  output      logic                CLK_OE_N,
  output      logic [23:0]         ADDR_OUT,
  output      logic                ADDR_OE_N,
  output      logic                RD_N,
  output      logic                WR_N,
  output      logic                UPPER_BYTE_STORE_STROBE_N,
  output      logic                BUS_WIDE,
  output      logic                INTERNAL_IO,
  output      logic                IO_WAIT_ONE,
  input  wire logic                MEM_ACK,
  input  wire logic [7:0]          MEM_DATA,
  input  wire logic                CORE_REQ,
  input  wire logic [23:0]         CORE_ADDR,
  input  wire logic                CORE_WE,
  input  wire logic                CORE_UPPER,
  input  wire logic                CORE_WAIT_STATE,
  input  wire logic                AREA_WIDE,
  output      logic                RUNNING,
  output      logic [23:0]         PC_OUT,
  input  wire logic                NMI_REQ,
  input  wire logic [NSRC-1:0]     MASK_REQ,
  input  wire logic [3*NSRC-1:0]   MASK_LEVELS,
  input  wire logic                TRAP_REQ,
  output      logic                IRQ_TAKE,
  output      logic [2:0]          IRQ_LEVEL,
  output      logic                IRQ_IS_NMI,
  output      logic                IRQ_IS_TRAP,
  input  wire logic                MASK_SET_INSTR,
  input  wire logic [2:0]          MASK_OPERAND,
  input  wire logic                MASK_ALL_INSTR,
  output      logic [2:0]          MASK_LEVEL_OUT
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic in_io(input logic [23:0] a);
    in_io = (a >= cpurst_pkg::IO_FIRST) && (a <= cpurst_pkg::IO_LAST);
  endfunction

  function automatic logic [2:0] mask_load(input logic [2:0] op);
    mask_load = (op == cpurst_pkg::LEVEL_NONE) ? cpurst_pkg::MASK_MIN : op;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic                    ack_ff;
  logic [31:0]             rdata_ff;
  logic                    wb_hit;
  logic                    wr_smc;
  logic                    wr_sr;
  logic                    wr_sp;
  logic                    clk_ts_ff;
  logic                    sys_ts_ff;
  logic                    psram_ff;
  logic [2:0]              mask_ff;
  logic [2:0]              nxt_mask;
  logic                    wide_ff;
  logic [2:0]              bank_ff;
  logic [31:0]             sp_ff;
  logic [23:0]             pc_ff;
  logic                    sync1_ff;
  logic                    sync2_ff;
  logic                    sync3_ff;
  logic [2:0]              fill_ff;
  logic                    strap_ff;
  logic                    strap_taken_ff;
  cpurst_pkg::cpurst_state_e state_ff;
  logic [3:0]              hold_cnt_ff;
  logic [1:0]              byte_idx_ff;
  logic                    ph_ff;
  logic                    div_ff;
  logic                    sys_pend_ff;
  logic                    sys_float_ff;
  logic                    clk_pend_ff;
  logic [1:0]              clk_step_ff;
  logic                    clk_float_ff;
  logic [23:0]             addr_ff;
  logic                    addr_oe_n_ff;
  logic                    rd_n_ff;
  logic                    wr_n_ff;
  logic                    hwr_n_ff;
  logic                    wide_acc_ff;
  logic                    int_io_ff;
  logic                    io_wait_ff;
  logic                    best_valid;
  logic [2:0]              best_level;
  logic                    best_nmi;

  // ------------------------------------------------------------------
  // Wishbone slave, one wait state, every address acknowledged
  // ------------------------------------------------------------------
  assign wb_hit = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr_smc = wb_hit && WB_WE_I && (WB_ADR_I == cpurst_pkg::REG_SMC) && WB_SEL_I[0];
  assign wr_sr  = wb_hit && WB_WE_I && (WB_ADR_I == cpurst_pkg::REG_SR) && WB_SEL_I[0];
  assign wr_sp  = wb_hit && WB_WE_I && (WB_ADR_I == cpurst_pkg::REG_SP);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_hit;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (wb_hit && !WB_WE_I) begin
      rdata_ff <= 32'h0000_0000;
      case (WB_ADR_I)
        cpurst_pkg::REG_SMC: begin
          rdata_ff[cpurst_pkg::SMC_CLK_TS] <= clk_ts_ff;
          rdata_ff[cpurst_pkg::SMC_SYS_TS] <= sys_ts_ff;
          rdata_ff[cpurst_pkg::SMC_PSRAM]  <= psram_ff;
        end
        cpurst_pkg::REG_SR: begin
          rdata_ff[cpurst_pkg::SR_MASK_LSB +: 3] <= mask_ff;
          rdata_ff[cpurst_pkg::SR_WIDE]          <= wide_ff;
          rdata_ff[cpurst_pkg::SR_BANK_LSB +: 3] <= bank_ff;
        end
        cpurst_pkg::REG_SP: begin
          rdata_ff <= sp_ff;
        end
        cpurst_pkg::REG_PC: begin
          rdata_ff[23:0] <= pc_ff;
        end
        cpurst_pkg::REG_INFO: begin
          rdata_ff[cpurst_pkg::INFO_STRAP] <= strap_ff;
          rdata_ff[cpurst_pkg::INFO_RUN]   <= (state_ff == cpurst_pkg::ST_RUN);
        end
        default: begin
          rdata_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;

  // ------------------------------------------------------------------
  // Standby mode control: tristate bits are set-only
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      clk_ts_ff <= 1'b0;
      sys_ts_ff <= 1'b0;
      psram_ff  <= 1'b0;
    end else if (wr_smc) begin
      clk_ts_ff <= clk_ts_ff | WB_DAT_I[cpurst_pkg::SMC_CLK_TS];
      sys_ts_ff <= sys_ts_ff | WB_DAT_I[cpurst_pkg::SMC_SYS_TS];
      psram_ff  <= WB_DAT_I[cpurst_pkg::SMC_PSRAM];
    end
  end

  // ------------------------------------------------------------------
  // Status register, stack pointer
  // ------------------------------------------------------------------
  // Instructions beat a bus write in the same cycle; the core owns the mask
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_sr) begin
      nxt_mask = WB_DAT_I[cpurst_pkg::SR_MASK_LSB +: 3];
    end
    if (MASK_SET_INSTR) begin
      nxt_mask = mask_load(MASK_OPERAND);
    end
    if (MASK_ALL_INSTR) begin
      nxt_mask = cpurst_pkg::MASK_ALL;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mask_ff <= cpurst_pkg::MASK_RESET;
      wide_ff <= 1'b1;
      bank_ff <= cpurst_pkg::BANK_RESET;
    end else begin
      mask_ff <= nxt_mask;
      if (wr_sr) begin
        bank_ff <= WB_DAT_I[cpurst_pkg::SR_BANK_LSB +: 3];
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sp_ff <= cpurst_pkg::SP_RESET;
    end else if (wr_sp) begin
      sp_ff <= merge(sp_ff, WB_DAT_I, WB_SEL_I);
    end
  end

  assign MASK_LEVEL_OUT = mask_ff;

  // ------------------------------------------------------------------
  // Bus width strap: three flops, latched once after release
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      fill_ff  <= 3'h0;
    end else begin
      sync1_ff <= BUS_WIDTH_STRAP;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      fill_ff  <= {fill_ff[1:0], 1'b1};
    end
  end

  // Waits for a settled strap, so a slow strap still lands before the fetch
  // The chain's reset zeros are not the pin, so nothing is taken until it fills
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      strap_ff       <= 1'b0;
      strap_taken_ff <= 1'b0;
    end else if (fill_ff[2] && !strap_taken_ff && (sync2_ff == sync3_ff)) begin
      strap_ff       <= sync3_ff;
      strap_taken_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Start-up: hold count, vector fetch, then run
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_ff    <= cpurst_pkg::ST_HOLD;
      hold_cnt_ff <= 4'h0;
      byte_idx_ff <= 2'h0;
      pc_ff       <= 24'h00_0000;
    end else begin
      case (state_ff)
        cpurst_pkg::ST_HOLD: begin
          hold_cnt_ff <= hold_cnt_ff + 4'h1;
          if (hold_cnt_ff == cpurst_pkg::ADDR_START_CLKS - 4'h1) begin
            state_ff <= cpurst_pkg::ST_FETCH;
          end
        end
        cpurst_pkg::ST_FETCH: begin
          if (MEM_ACK && !rd_n_ff) begin
            pc_ff[8*byte_idx_ff +: 8] <= MEM_DATA;
            byte_idx_ff <= byte_idx_ff + 2'h1;
            if (byte_idx_ff == 2'(cpurst_pkg::VEC_BYTES - 1)) begin
              state_ff <= cpurst_pkg::ST_RUN;
            end
          end
        end
        cpurst_pkg::ST_RUN: begin
          state_ff <= cpurst_pkg::ST_RUN;
        end
        default: begin
          state_ff <= cpurst_pkg::ST_HOLD;
        end
      endcase
    end
  end

  assign RUNNING = (state_ff == cpurst_pkg::ST_RUN);
  assign PC_OUT  = pc_ff;

  // ------------------------------------------------------------------
  // Clock outputs: half rate and quarter rate, pin high in reset
  // ------------------------------------------------------------------
  // ph_ff high is the second phase; a 0 to 1 step is its rising edge
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ph_ff  <= 1'b0;
      div_ff <= 1'b1;
    end else begin
      ph_ff <= !ph_ff;
      if (ph_ff) begin
        div_ff <= !div_ff;
      end
    end
  end

  // Float points wait for phase edges so the sysclk pin never ends in a runt pulse; the clock pin's last level lasts one MCLK cycle
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sys_pend_ff  <= 1'b0;
      sys_float_ff <= 1'b0;
    end else begin
      if (wr_smc && WB_DAT_I[cpurst_pkg::SMC_SYS_TS] && !sys_float_ff) begin
        sys_pend_ff <= 1'b1;
      end else if (sys_pend_ff && !ph_ff) begin
        sys_pend_ff  <= 1'b0;
        sys_float_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      clk_pend_ff  <= 1'b0;
      clk_step_ff  <= 2'h0;
      clk_float_ff <= 1'b0;
    end else begin
      if (wr_smc && WB_DAT_I[cpurst_pkg::SMC_CLK_TS] && !clk_float_ff && !clk_pend_ff) begin
        clk_pend_ff <= 1'b1;
        clk_step_ff <= 2'h0;
      end else if (clk_pend_ff && !ph_ff) begin
        clk_step_ff <= clk_step_ff + 2'h1;
        if (clk_step_ff == cpurst_pkg::CLK_FLOAT_STEPS - 2'h1) begin
          clk_pend_ff  <= 1'b0;
          clk_float_ff <= 1'b1;
        end
      end
    end
  end

  assign SYSTEM_CLOCK_OUTPUT = ph_ff;
  assign SYSTEM_CLOCK_OE_N   = sys_float_ff;
  assign CLK_OUT             = div_ff;
  assign CLK_OE_N            = clk_float_ff;

  // ------------------------------------------------------------------
  // External bus strobes and address
  // ------------------------------------------------------------------
  // Registered one cycle behind the core request to keep the pins glitch-free
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      addr_ff      <= 24'h00_0000;
      addr_oe_n_ff <= 1'b1;
      rd_n_ff      <= 1'b1;
      wr_n_ff      <= 1'b1;
      hwr_n_ff     <= 1'b1;
      wide_acc_ff  <= 1'b0;
      int_io_ff    <= 1'b0;
      io_wait_ff   <= 1'b0;
    end else begin
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
      hwr_n_ff    <= 1'b1;
      int_io_ff   <= 1'b0;
      io_wait_ff  <= 1'b0;
      wide_acc_ff <= 1'b0;
      case (state_ff)
        cpurst_pkg::ST_HOLD: begin
          addr_oe_n_ff <= 1'b1;
        end
        cpurst_pkg::ST_FETCH: begin
          addr_oe_n_ff <= 1'b0;
          addr_ff      <= cpurst_pkg::VEC_BASE + {22'h00_0000, byte_idx_ff};
          rd_n_ff      <= MEM_ACK && !rd_n_ff;
        end
        cpurst_pkg::ST_RUN: begin
          if (CORE_REQ) begin
            addr_ff <= CORE_ADDR;
            if (in_io(CORE_ADDR)) begin
              int_io_ff  <= 1'b1;
              io_wait_ff <= CORE_WAIT_STATE;
              rd_n_ff    <= !(psram_ff && !CORE_WE);
            end else begin
              wide_acc_ff <= AREA_WIDE && !strap_ff;
              rd_n_ff     <= CORE_WE;
              wr_n_ff     <= !CORE_WE;
              hwr_n_ff    <= !(CORE_WE && CORE_UPPER && AREA_WIDE && !strap_ff);
            end
          end
        end
        default: begin
          addr_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  assign ADDR_OUT                  = addr_ff;
  assign ADDR_OE_N                 = addr_oe_n_ff;
  assign RD_N                      = rd_n_ff;
  assign WR_N                      = wr_n_ff;
  assign UPPER_BYTE_STORE_STROBE_N = hwr_n_ff;
  assign BUS_WIDE                  = wide_acc_ff;
  assign INTERNAL_IO               = int_io_ff;
  assign IO_WAIT_ONE               = io_wait_ff;

  // ------------------------------------------------------------------
  // Interrupt priority and acceptance
  // ------------------------------------------------------------------
  // Level 0 means disabled; lower index wins a tie
  always_comb begin
    best_valid = NMI_REQ;
    best_level = NMI_REQ ? cpurst_pkg::NMI_LEVEL : cpurst_pkg::LEVEL_NONE;
    best_nmi   = NMI_REQ;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (MASK_REQ[i] && (MASK_LEVELS[3*i +: 3] != cpurst_pkg::LEVEL_NONE) &&
          !NMI_REQ && (MASK_LEVELS[3*i +: 3] >= best_level)) begin
        best_valid = 1'b1;
        best_level = MASK_LEVELS[3*i +: 3];
      end
    end
  end

  // Acceptance is combinational, so a new mask acts from the next cycle on
  assign IRQ_IS_TRAP = TRAP_REQ;
  assign IRQ_TAKE    = RUNNING && (TRAP_REQ || (best_valid && (best_level >= mask_ff)));
  assign IRQ_LEVEL   = TRAP_REQ ? cpurst_pkg::NMI_LEVEL : best_level;
  assign IRQ_IS_NMI  = !TRAP_REQ && best_nmi;

endmodule

// File: logic/cpurst_pkg.sv
package cpurst_pkg;
  // ------------------------------------------------------------------
  // Address map of the core
  // ------------------------------------------------------------------
  localparam int          ADDR_W       = 24;
  localparam logic [23:0] VEC_BASE     = 24'hFF_FF00;
  localparam logic [23:0] IO_FIRST     = 24'h00_0000;
  localparam logic [23:0] IO_LAST      = 24'h00_003F;
  localparam int          VEC_BYTES    = 3;

  // ------------------------------------------------------------------
  // Reset values of core state, mask and interrupt levels
  // ------------------------------------------------------------------
  localparam logic [31:0] SP_RESET     = 32'h0000_0100;
  localparam logic [2:0]  MASK_RESET   = 3'h7;
  localparam logic [2:0]  BANK_RESET   = 3'h0;
  localparam logic [2:0]  MASK_ALL     = 3'h7;
  localparam logic [2:0]  MASK_MIN     = 3'h1;
  localparam logic [2:0]  LEVEL_NONE   = 3'h0;
  localparam logic [2:0]  NMI_LEVEL    = 3'h7;

  // ------------------------------------------------------------------
  // Timing in clock states, clock period in ns
  // ------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          RST_MIN_STATES  = 10;
  localparam logic [3:0]  ADDR_START_CLKS = 4'hA;
  localparam logic [1:0]  CLK_FLOAT_STEPS = 2'h2;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_SMC      = 8'h00;
  localparam logic [7:0]  REG_SR       = 8'h04;
  localparam logic [7:0]  REG_SP       = 8'h08;
  localparam logic [7:0]  REG_PC       = 8'h0C;
  localparam logic [7:0]  REG_INFO     = 8'h10;
  localparam int          SMC_CLK_TS   = 0;
  localparam int          SMC_SYS_TS   = 1;
  localparam int          SMC_PSRAM    = 2;
  localparam int          SR_MASK_LSB  = 0;
  localparam int          SR_WIDE      = 3;
  localparam int          SR_BANK_LSB  = 4;
  localparam int          INFO_STRAP   = 0;
  localparam int          INFO_RUN     = 1;

  typedef enum {ST_HOLD, ST_FETCH, ST_RUN} cpurst_state_e;
endpackage

// File: tb/cpurst_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------
// Port checker for the system-control block
// ------------------------------------------
module cpurst_chk (
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic        SYSTEM_CLOCK_OUTPUT,
  input wire logic        CLK_OUT,
  input wire logic        ADDR_OE_N,
  input wire logic        RD_N,
  input wire logic        WR_N,
  input wire logic        UPPER_BYTE_STORE_STROBE_N,
  input wire logic        INTERNAL_IO,
  input wire logic        RUNNING,
  input wire logic        CORE_REQ,
  input wire logic [23:0] CORE_ADDR,
  input wire logic        CORE_WE,
  input wire logic        TRAP_REQ,
  input wire logic        IRQ_TAKE,
  input wire logic        IRQ_IS_TRAP,
  input wire logic        MASK_SET_INSTR,
  input wire logic [2:0]  MASK_OPERAND,
  input wire logic        MASK_ALL_INSTR,
  input wire logic [2:0]  MASK_LEVEL_OUT
);
  // Edges since release, saturating so a long run never wraps
  logic [3:0] cnt_ff;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  AST_ADDR_START: assert property (cnt_ff == 4'hB |-> $fell(ADDR_OE_N))
    else $error("address drive start off");
  AST_IO_QUIET: assert property (
    RUNNING && CORE_REQ && CORE_ADDR <= 24'h00_003F
    |=> WR_N && UPPER_BYTE_STORE_STROBE_N && INTERNAL_IO)
    else $error("write strobe in io window");
  AST_EXT_READ: assert property (
    RUNNING && CORE_REQ && CORE_ADDR > 24'h00_003F && !CORE_WE
    |=> !RD_N && WR_N && !INTERNAL_IO)
    else $error("external read strobe wrong");
  AST_MASK_ALL: assert property (MASK_ALL_INSTR |=> MASK_LEVEL_OUT == 3'h7)
    else $error("mask all not seven");
  AST_MASK_SET: assert property (
    MASK_SET_INSTR && !MASK_ALL_INSTR |=> MASK_LEVEL_OUT ==
    (($past(MASK_OPERAND) == 3'h0) ? 3'h1 : $past(MASK_OPERAND)))
    else $error("mask set value wrong");
  AST_TRAP_TAKEN: assert property (RUNNING && TRAP_REQ |-> IRQ_TAKE && IRQ_IS_TRAP)
    else $error("trap not taken");
  AST_SYS_TOGGLE: assert property (
    $past(NRST) |-> SYSTEM_CLOCK_OUTPUT != $past(SYSTEM_CLOCK_OUTPUT))
    else $error("half rate clock stuck");
  AST_CLK_DIV: assert property (
    $past(NRST) && $changed(CLK_OUT) |=> $stable(CLK_OUT) ##1 $changed(CLK_OUT))
    else $error("quarter rate clock wrong");
  cover property (RUNNING && TRAP_REQ);
  cover property (MASK_SET_INSTR && MASK_OPERAND == 3'h0);
  cover property (RUNNING && CORE_REQ && CORE_ADDR <= 24'h00_003F && !CORE_WE);
endmodule

bind cpurst_top cpurst_chk u_chk (
  .MCLK, .NRST, .SYSTEM_CLOCK_OUTPUT, .CLK_OUT, .ADDR_OE_N, .RD_N, .WR_N,
  .UPPER_BYTE_STORE_STROBE_N, .INTERNAL_IO, .RUNNING, .CORE_REQ, .CORE_ADDR,
  .CORE_WE, .TRAP_REQ, .IRQ_TAKE, .IRQ_IS_TRAP, .MASK_SET_INSTR, .MASK_OPERAND,
  .MASK_ALL_INSTR, .MASK_LEVEL_OUT);

// File: tb/cpurst_mem.sv
`timescale 1ns/1ps
// ----------------------------------
// Vector memory seen during startup
// ----------------------------------
module cpurst_mem #(
  parameter logic [23:0] VEC = 24'h00_0000
) (
  input  wire logic        MCLK,
  input  wire logic        ADDR_OE_N,
  input  wire logic [23:0] ADDR_OUT,
  input  wire logic        slow,
  output      logic        MEM_ACK,
  output      logic [7:0]  MEM_DATA
);
  logic [7:0] age_ff;
  // Slow mode holds the answer back a few cycles after the bus wakes
  always_ff @(posedge MCLK) begin
    age_ff <= ADDR_OE_N ? 8'h00 : age_ff + 8'h01;
  end
  assign MEM_ACK = !ADDR_OE_N && (!slow || age_ff > 8'h04);
  // Idle data keeps moving so a stale byte cannot pass
  assign MEM_DATA = MEM_ACK ? VEC[8*ADDR_OUT[1:0] +: 8] : ~age_ff;
endmodule

// File: tb/cpurst_test.sv
`timescale 1ns/1ps
// ------------------------------
// Self-checking bench
// ------------------------------
module cpurst_test;
  localparam logic [23:0] VEC = 24'h3A_5C71;
  logic        MCLK = 1'b0;
  logic        NRST, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, BUS_WIDTH_STRAP, slow;
  logic        SYSTEM_CLOCK_OUTPUT, SYSTEM_CLOCK_OE_N, CLK_OUT, CLK_OE_N, ADDR_OE_N;
  logic        RD_N, WR_N, UPPER_BYTE_STORE_STROBE_N, BUS_WIDE, INTERNAL_IO, IO_WAIT_ONE;
  logic        MEM_ACK, CORE_REQ, CORE_WE, CORE_UPPER, CORE_WAIT_STATE, AREA_WIDE, RUNNING;
  logic        NMI_REQ, TRAP_REQ, IRQ_TAKE, IRQ_IS_NMI, IRQ_IS_TRAP;
  logic        MASK_SET_INSTR, MASK_ALL_INSTR;
  logic [7:0]  WB_ADR_I, MEM_DATA;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic [3:0]  WB_SEL_I, MASK_REQ, rq;
  logic [11:0] MASK_LEVELS, lv;
  logic [23:0] ADDR_OUT, CORE_ADDR, PC_OUT;
  logic [2:0]  IRQ_LEVEL, MASK_OPERAND, MASK_LEVEL_OUT, mask, opd, best;
  logic        nmi, tr;
  int          errors = 0, n_tests = 0, op;

  cpurst_top dut (.*);
  cpurst_mem #(.VEC(VEC)) mem (.*);
  always #10 MCLK = ~MCLK;

  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(posedge MCLK);
      n++;
    end
    if (n == 200) begin
      errors++;
      close_out();
    end
  endtask
  // Classic single cycle, held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {2'h3, we, a, d, 4'hF};
    @(posedge MCLK);
    wait_hi(WB_ACK_O);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask
  // Back-to-back core requests, checked one cycle behind
  task automatic access(input logic psr, input logic st);
    logic [29:0] e[$];
    logic [23:0] a;
    logic we, up, aw, cw, io;
    for (int i = 0; i <= 24; i++) begin
      @(posedge MCLK);
      a = i[0] ? 24'($urandom) : 24'($urandom_range(95, 31));
      {we, up, aw, cw} = 4'($urandom);
      io = a <= 24'h00_003F;
      {CORE_REQ, CORE_ADDR, CORE_WE, CORE_UPPER, AREA_WIDE, CORE_WAIT_STATE}
        <= {i < 24, a, we, up, aw, cw};
      e.push_back({a, io ? !(psr && !we) : we, io | !we, io | !we | !up | !aw | st,
                   !io & aw & !st, io, io & cw});
      @(negedge MCLK);
      if (i > 0) cmp({ADDR_OUT, RD_N, WR_N, UPPER_BYTE_STORE_STROBE_N, BUS_WIDE, INTERNAL_IO,
                      INTERNAL_IO & IO_WAIT_ONE}, e.pop_front());
    end
  endtask

  initial begin
    {NRST, WB_WE_I, WB_CYC_I, WB_STB_I, BUS_WIDTH_STRAP, slow, CORE_REQ, CORE_WE} = '0;
    {CORE_UPPER, CORE_WAIT_STATE, AREA_WIDE, NMI_REQ, TRAP_REQ, MASK_SET_INSTR} = '0;
    {MASK_ALL_INSTR, WB_ADR_I, WB_DAT_I, WB_SEL_I, MASK_REQ, MASK_LEVELS} = '0;
    {CORE_ADDR, MASK_OPERAND} = '0;
    void'($urandom(32'h80e2_e1f8));
    for (int p = 0; p < 2; p++) begin
      {NRST, BUS_WIDTH_STRAP, slow} <= {1'b0, p == 0, p == 0};
      repeat (10) @(posedge MCLK);
      cmp({CLK_OUT, CLK_OE_N, SYSTEM_CLOCK_OE_N}, 32'h4);
      NRST <= 1'b1;
      wb(1'b0, 8'h00, 32'h0); cmp(q, 32'h0);
      wb(1'b0, 8'h04, 32'h0); cmp(q, 32'h0000_000F);
      wb(1'b0, 8'h08, 32'h0); cmp(q, 32'h0000_0100);
      wb(1'b0, 8'h20, 32'h0); cmp(q, 32'h0);
      wait_hi(RUNNING);
      wb(1'b0, 8'h0C, 32'h0); cmp(q, {8'h00, VEC});
      cmp(PC_OUT, VEC);
      BUS_WIDTH_STRAP <= p != 0;
      repeat (5) @(posedge MCLK);
      wb(1'b0, 8'h10, 32'h0); cmp(q, {30'h0, 1'b1, p == 0});
      access(1'b0, p == 0);
      wb(1'b1, 8'h00, 32'h4);
      access(1'b1, p == 0);
      mask = 3'h7;
      repeat (40) begin
        @(posedge MCLK);
        op = $urandom_range(2);
        {opd, rq} = 7'($urandom);
        nmi = $urandom_range(5) == 0;
        tr = $urandom_range(5) == 0;
        best = nmi ? 3'h7 : 3'h0;
        for (int j = 0; j < 4; j++) begin
          lv[3*j +: 3] = 3'($urandom_range(6));
          if (rq[j] && lv[3*j +: 3] > best) best = lv[3*j +: 3];
        end
        {MASK_SET_INSTR, MASK_ALL_INSTR, MASK_OPERAND} <= {op == 1, op == 2, opd};
        {NMI_REQ, TRAP_REQ, MASK_REQ, MASK_LEVELS} <= {nmi, tr, rq, lv};
        if (op != 0) mask = (op == 2) ? 3'h7 : ((opd == 3'h0) ? 3'h1 : opd);
        @(posedge MCLK);
        {MASK_SET_INSTR, MASK_ALL_INSTR} <= 2'h0;
        @(negedge MCLK);
        cmp(MASK_LEVEL_OUT, mask);
        if (tr) cmp({IRQ_TAKE, IRQ_IS_TRAP}, 2'h3);
        else cmp({IRQ_TAKE, IRQ_LEVEL, IRQ_IS_NMI}, {best >= mask, best, nmi});
      end
      @(posedge MCLK);
      {NMI_REQ, TRAP_REQ} <= 2'h0;
      wb(1'b1, 8'h04, 32'h0000_005B);
      wb(1'b0, 8'h04, 32'h0); cmp(q, 32'h0000_005B);
      wb(1'b1, 8'h08, 32'h1234_5678);
      wb(1'b0, 8'h08, 32'h0); cmp(q, 32'h1234_5678);
      cmp({CLK_OE_N, SYSTEM_CLOCK_OE_N}, 32'h0);
      wb(1'b1, 8'h00, 32'h3);
      wait_hi(SYSTEM_CLOCK_OE_N);
      cmp(CLK_OE_N, 32'h0);
      repeat (2) @(posedge MCLK);
      cmp(CLK_OE_N, 32'h1);
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b0, 8'h00, 32'h0); cmp(q, 32'h3);
    end
    close_out();
  end
endmodule
